// ==== bench/cld_codec_link_dma_test.sv ====
`timescale 1ns/1ps
`include "cld_params.svh"
module cld_codec_link_dma_test;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, ttx = 32'h0, stx = 32'h0;
   logic hready, hreadyout, hresp, sclk, fsync, din, dout, sreq_rx, sreq_tx, treq_rx, treq_tx, tflag;
   logic men = 1'b0, sen = 1'b0, ten = 1'b0, sf0e = 1'b0, sf1e = 1'b0, tsel = 1'b0;
   logic tick = 1'b0, sack = 1'b0, tack = 1'b0;
   logic [11:0] size = 12'h3;
   logic [11:0] sptr, tptr;
   logic [31:0] hrdata, hold, rdv, c0, c1, c2, s0, d0, s1, d1;
   logic [127:0] rxf;
   logic [1:0] slog[$];
   logic [1:0] tlog[$];
   logic [7:0] ro[4] = '{8'h7c, 8'h88, 8'h8c, 8'ha0};
   int n_fail = 0;
   int cmp_count = 0;
   int nflag = 0;

   cld_codec_link_dma cld_codec_link_dma_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .link_sclk(sclk), .link_fsync(fsync), .link_din(din), .link_dout(dout),
      .module_enable(men), .sound_enable(sen), .telecom_enable(ten), .subframe0_enable(sf0e),
      .subframe1_enable(sf1e), .telecom_sf1_select(tsel), .telecom_tx_word(ttx), .sound_tx_word(stx),
      .sound_sample_tick(tick), .dma_buffer_size(size), .telecom_rx_holding(hold), .telecom_input_flag(tflag),
      .sound_dma_rx_req(sreq_rx), .sound_dma_tx_req(sreq_tx), .sound_dma_ack(sack),
      .telecom_dma_rx_req(treq_rx), .telecom_dma_tx_req(treq_tx), .telecom_dma_ack(tack),
      .sound_dma_pointer(sptr), .telecom_dma_pointer(tptr));
   cld_codec_model cld_codec_model_inst (.link_sclk(sclk), .link_fsync(fsync), .link_din(din), .link_dout(dout));
   assign hready = hreadyout;

   initial begin
      forever #50 hclk = ~hclk;
   end
   // Stand-in DMA engine: logs which request each ack answered
   always @(posedge hclk) begin
      sack <= (sreq_rx | sreq_tx) & ~sack;
      tack <= (treq_rx | treq_tx) & ~tack;
      if (sack === 1'b1) slog.push_back({sreq_rx, sreq_tx});
      if (tack === 1'b1) tlog.push_back({treq_rx, treq_tx});
      if (tflag === 1'b1) nflag++;
   end
   task stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask
   task edge_rdy;
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hready !== 1'b1 && i < 50);
      if (hready !== 1'b1) begin
         n_fail++;
         stop_test();
      end
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      edge_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      edge_rdy();
      rdv = hrdata;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input string m);
      ahb(1'b0, a, 32'h0);
      chk(rdv, e, m);
      chk({31'h0, hresp}, 32'h0, "response");
   endtask
   task frame(input logic [31:0] a0, input logic [31:0] b0, input logic [31:0] a1, input logic [31:0] b1);
      cld_codec_model_inst.frame({a0, b0, a1, b1}, rxf);
      // A word in the last slot is still in its DMA service when the frame ends
      repeat (8) @(posedge hclk);
   endtask
   task pulse_tick;
      tick <= 1'b1;
      @(posedge hclk);
      tick <= 1'b0;
      repeat (8) @(posedge hclk);
   endtask
   function automatic logic [1:0] ord(input logic rx_first);
      return rx_first ? 2'b10 : 2'b01;
   endfunction
   // m[1] single pass, m[0] receive first; one service more than the buffer holds
   task dma_run(input logic ch, input logic [1:0] m);
      logic [31:0] w;
      logic [1:0] q[$];
      w = ch ? {16'h0, m, 12'hfff, 2'b11} : {m, 12'hfff, 2'b11, 16'h0};
      ahb(1'b1, `CLD_OFF_DMA_CTL, w);
      rd(`CLD_OFF_DMA_CTL, w & `CLD_DMA_WMASK, "dma mode");
      for (int s = 0; s <= size; s++) begin
         slog.delete();
         tlog.delete();
         if (ch)
            frame($urandom, $urandom, $urandom, $urandom);
         else
            pulse_tick();
         if (ch)
            q = tlog;
         else
            q = slog;
         chk(32'(q.size()), (m[1] && s == size) ? 32'h0 : 32'h2, "services");
         if (q.size() == 2) begin
            chk({30'h0, q[0]}, {30'h0, ord(m[0])}, "first request");
            chk({30'h0, q[1]}, {30'h0, ord(!m[0])}, "second request");
         end
         chk({20'h0, ch ? tptr : sptr}, (m[1] && s == size) ? 32'h0 : (s + 1) % size, "pointer");
      end
      rd(`CLD_OFF_DMA_CTL, (w & `CLD_DMA_WMASK) | ((m[1] ? 32'h0 : 32'h1) << (ch ? 2 : 18)), "ptr");
      ahb(1'b1, `CLD_OFF_DMA_CTL, 32'h0);
   endtask

   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      void'($urandom(59));
      for (int i = 0; i < 6; i++)
         rd(8'h7c + 8'(4 * i), 32'h0, "reset value");
      {c0, c1, c2} = {$urandom, $urandom, $urandom};
      ahb(1'b1, `CLD_OFF_SF0_CTRL, c0);
      ahb(1'b1, `CLD_OFF_SF1_CTRL, c1);
      rd(`CLD_OFF_SF0_CTRL, c0, "ctrl0");
      rd(`CLD_OFF_SF1_CTRL, c1, "ctrl1");
      for (int i = 0; i < 4; i++)
         ahb(1'b1, ro[i], $urandom);
      for (int i = 0; i < 4; i++)
         rd(ro[i], 32'h0, "read-only or unmapped");
      men <= 1'b1;
      sen <= 1'b1;
      ten <= 1'b1;
      sf0e <= 1'b1;
      sf1e <= 1'b1;
      tsel <= 1'($urandom);
      ttx <= $urandom;
      stx <= $urandom;
      for (int f = 0; f < 3; f++) begin
         {s0, d0, s1, d1} = {$urandom, $urandom, $urandom, $urandom};
         fork
            frame(s0, d0, s1, d1);
            // Rewrite lands after slot 0 has gone out, so it shows next frame
            if (f == 1) begin
               repeat (600) @(posedge hclk);
               ahb(1'b1, `CLD_OFF_SF0_CTRL, c2);
            end
         join
         chk(rxf[127:96], c0, "ctrl0 sent");
         chk(rxf[63:32], c1, "ctrl1 sent");
         chk(tsel ? rxf[31:0] : rxf[95:64], ttx, "telecom slot");
         chk(tsel ? rxf[95:64] : rxf[31:0], stx, "sound slot");
         rd(`CLD_OFF_SF0_STAT, s0, "status0");
         rd(`CLD_OFF_SF1_STAT, s1, "status1");
         rd(`CLD_OFF_TEL_HOLD, tsel ? d1 : d0, "telecom word");
         chk(hold, tsel ? d1 : d0, "holding port");
         chk(32'(nflag), 32'(f + 1), "telecom flag");
         if (f == 1)
            c0 = c2;
      end
      sf1e <= 1'b0;
      frame(s0, d0, ~s1, ~d1);
      chk(rxf[63:32], 32'h0, "disabled ctrl");
      chk(rxf[31:0], 32'h0, "disabled data");
      rd(`CLD_OFF_SF1_STAT, s1, "status1 kept");
      sf1e <= 1'b1;
      for (int m = 0; m < 4; m++)
         dma_run(1'b0, 2'(m));
      for (int e = 1; e < 3; e++) begin
         ahb(1'b1, `CLD_OFF_DMA_CTL, {14'h0, 2'(e), 16'h0});
         slog.delete();
         pulse_tick();
         chk(32'(slog.size()), 32'h1, "one direction");
         chk({30'h0, slog[0]}, 32'(e), "direction");
      end
      ahb(1'b1, `CLD_OFF_DMA_CTL, 32'h0);
      size <= 12'h2;
      for (int m = 1; m < 3; m++)
         dma_run(1'b1, 2'(m));
      stop_test();
   end
endmodule // cld_codec_link_dma_test

// ==== bench/cld_codec_model.sv ====
`timescale 1ns/1ps
module cld_codec_model (
   output logic link_sclk,
   output logic link_fsync,
   output logic link_din,
   input wire logic link_dout
);
   // Idle clock stands high so that bit 0 too begins on a falling edge
   initial begin
      link_sclk = 1'b1;
      link_fsync = 1'b0;
      link_din = 1'b0;
   end
   task automatic frame(input logic [127:0] tx, output logic [127:0] rx);
      #37;
      for (int k = 0; k < 128; k++) begin
         link_sclk = 1'b0;
         link_fsync = (k == 0);
         link_din = tx[127 - k];
         #400;
         link_sclk = 1'b1;
         rx[127 - k] = link_dout;
         #400;
      end
      link_fsync = 1'b0;
      // Released line must not keep showing its last bit
      link_din = ~link_din;
   endtask
endmodule // cld_codec_model

// ==== design/cld_codec_link_dma.sv ====
`timescale 1ns/1ps
`include "cld_params.svh"

module cld_codec_link_dma (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic link_sclk,
   input wire logic link_fsync,
   input wire logic link_din,
   output logic link_dout,
   input wire logic module_enable,
   input wire logic sound_enable,
   input wire logic telecom_enable,
   input wire logic subframe0_enable,
   input wire logic subframe1_enable,
   input wire logic telecom_sf1_select,
   input wire logic [31:0] telecom_tx_word,
   input wire logic [31:0] sound_tx_word,
   input wire logic sound_sample_tick,
   input wire logic [`CLD_PTR_W-1:0] dma_buffer_size,
   output logic [31:0] telecom_rx_holding,
   output logic telecom_input_flag,
   output logic sound_dma_rx_req,
   output logic sound_dma_tx_req,
   input wire logic sound_dma_ack,
   output logic telecom_dma_rx_req,
   output logic telecom_dma_tx_req,
   input wire logic telecom_dma_ack,
   output logic [`CLD_PTR_W-1:0] sound_dma_pointer,
   output logic [`CLD_PTR_W-1:0] telecom_dma_pointer
);
   import cld_pkg::*;

   cld_state_s q;
   cld_state_s n;
   logic rise;
   logic fall;
   logic [6:0] bitpos;
   logic ap_valid;
   logic [31:0] tx_word;

   function automatic logic sf_on(input logic sf);
      return sf ? subframe1_enable : subframe0_enable;
   endfunction

   // Word driven in one of the four 32-bit slots of a frame
   function automatic logic [31:0] slot_word(input cld_state_s s, input logic [1:0] slot);
      logic [31:0] data;
      data = (slot[1] == telecom_sf1_select) ? (telecom_enable ? telecom_tx_word : 32'h0000_0000)
                                              : (sound_enable ? sound_tx_word : 32'h0000_0000);
      unique case (slot)
         2'h0: return s.sf0_ctrl;
         2'h2: return s.sf1_ctrl;
         default: return data;
      endcase
   endfunction

   // One DMA channel: up to two ordered requests per sample, then pointer step
   function automatic cld_chan_s chan_next(input cld_chan_s c, input logic tick, input logic rxen,
                                           input logic txen, input logic rxfirst, input logic single,
                                           input logic ack);
      cld_chan_s r;
      logic first_on;
      logic second_on;
      r = c;
      first_on = rxfirst ? rxen : txen;
      second_on = rxfirst ? txen : rxen;
      if (!rxen && !txen) begin
         // Disabling both directions rearms the channel at buffer start
         r.phase = CLD_IDLE;
         r.ptr = '0;
         r.halted = 1'b0;
      end else begin
         unique case (c.phase)
            CLD_IDLE: begin
               if (tick && !c.halted) begin
                  r.phase = CLD_FIRST;
               end
            end
            CLD_FIRST: begin
               if (ack || !first_on) begin
                  r.phase = CLD_SECOND;
               end
            end
            CLD_SECOND: begin
               if (ack || !second_on) begin
                  r.phase = CLD_IDLE;
                  if (c.ptr == dma_buffer_size - 12'h001) begin
                     r.ptr = '0;
                     r.halted = single;
                  end else begin
                     r.ptr = c.ptr + 12'h001;
                  end
               end
            end
         endcase
      end
      return r;
   endfunction

   function automatic logic [1:0] chan_req(input cld_chan_s c, input logic rxen, input logic txen,
                                           input logic rxfirst);
      logic rx_now;
      rx_now = (c.phase == CLD_FIRST) ? rxfirst : !rxfirst;
      if (c.phase == CLD_IDLE) begin
         return 2'b00;
      end
      return {rx_now & rxen, !rx_now & txen};
   endfunction

   always_comb begin
      n = q;
      n.tel_flag = 1'b0;
      ap_valid = hsel & htrans[1] & hready;

      // The second stage of each synchroniser feeds logic, and the third sclk stage feeds edge detection
      n.sclk_sync = {q.sclk_sync[1:0], link_sclk};
      n.din_sync = {q.din_sync[0], link_din};
      n.fsync_sync = {q.fsync_sync[0], link_fsync};
      rise = q.sclk_sync[1] & ~q.sclk_sync[2];
      fall = ~q.sclk_sync[1] & q.sclk_sync[2];
      bitpos = q.fsync_sync[1] ? 7'h00 : q.bitcnt;
      // Named word, since a call result cannot be bit-selected
      tx_word = slot_word(q, q.bitcnt[6:5]);

      if (!module_enable) begin
         n.bitcnt = 7'h00;
         n.dout = 1'b0;
         n.rx_shift = 32'h0000_0000;
      end else begin
         if (rise) begin
            n.rx_shift = {q.rx_shift[30:0], q.din_sync[1]};
            n.bitcnt = bitpos + 7'h01;
            if (bitpos[4:0] == `CLD_WORD_LAST && sf_on(bitpos[6])) begin
               unique case (bitpos[6:5])
                  2'h0: n.sf0_stat = n.rx_shift;
                  2'h2: n.sf1_stat = n.rx_shift;
                  default: begin
                     if (telecom_enable && bitpos[6] == telecom_sf1_select) begin
                        n.tel_hold = n.rx_shift;
                        n.tel_flag = 1'b1;
                     end
                  end
               endcase
            end
         end
         // Output changes on the falling edge so it is settled at the sampling edge
         if (fall) begin
            n.dout = sf_on(q.bitcnt[6]) ? tx_word[~q.bitcnt[4:0]] : 1'b0;
         end
      end

      n.snd = chan_next(q.snd, sound_sample_tick, q.dma_ctl[`CLD_SND_RXEN], q.dma_ctl[`CLD_SND_TXEN],
                        q.dma_ctl[`CLD_SND_RXFIRST], q.dma_ctl[`CLD_SND_SINGLE], sound_dma_ack);
      n.tel = chan_next(q.tel, q.tel_flag, q.dma_ctl[`CLD_TEL_RXEN], q.dma_ctl[`CLD_TEL_TXEN],
                        q.dma_ctl[`CLD_TEL_RXFIRST], q.dma_ctl[`CLD_TEL_SINGLE], telecom_dma_ack);

      // Data phase of the previous write
      if (q.ap_write) begin
         unique case (q.ap_addr)
            `CLD_OFF_SF0_CTRL: n.sf0_ctrl = hwdata;
            `CLD_OFF_SF1_CTRL: n.sf1_ctrl = hwdata;
            `CLD_OFF_DMA_CTL: n.dma_ctl = hwdata & `CLD_DMA_WMASK;
            default: ;
         endcase
      end

      n.ap_write = ap_valid & hwrite;
      n.ap_addr = haddr[7:0];
      // Read value taken from the next state, so a write just before it is seen
      if (ap_valid && !hwrite) begin
         unique case (haddr[7:0])
            `CLD_OFF_TEL_HOLD: n.rdata = n.tel_hold;
            `CLD_OFF_SF0_CTRL: n.rdata = n.sf0_ctrl;
            `CLD_OFF_SF1_CTRL: n.rdata = n.sf1_ctrl;
            `CLD_OFF_SF0_STAT: n.rdata = n.sf0_stat;
            `CLD_OFF_SF1_STAT: n.rdata = n.sf1_stat;
            `CLD_OFF_DMA_CTL: begin
               n.rdata = n.dma_ctl;
               n.rdata[`CLD_SND_PTR_LSB +: `CLD_PTR_W] = n.snd.ptr;
               n.rdata[`CLD_TEL_PTR_LSB +: `CLD_PTR_W] = n.tel.ptr;
            end
            default: n.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign link_dout = q.dout;
   assign telecom_rx_holding = q.tel_hold;
   assign telecom_input_flag = q.tel_flag;
   assign {sound_dma_rx_req, sound_dma_tx_req} = chan_req(q.snd, q.dma_ctl[`CLD_SND_RXEN],
                                                          q.dma_ctl[`CLD_SND_TXEN],
                                                          q.dma_ctl[`CLD_SND_RXFIRST]);
   assign {telecom_dma_rx_req, telecom_dma_tx_req} = chan_req(q.tel, q.dma_ctl[`CLD_TEL_RXEN],
                                                              q.dma_ctl[`CLD_TEL_TXEN],
                                                              q.dma_ctl[`CLD_TEL_RXFIRST]);
   assign sound_dma_pointer = q.snd.ptr;
   assign telecom_dma_pointer = q.tel.ptr;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_CTRL_WRITE: assert property (q.ap_write && q.ap_addr == `CLD_OFF_SF0_CTRL |=>
      q.sf0_ctrl == $past(hwdata)) else $error("control word 0 write lost");
   AST_CTRL_KEEP: assert property (!(q.ap_write && q.ap_addr == `CLD_OFF_SF1_CTRL) |=>
      $stable(q.sf1_ctrl)) else $error("control word 1 changed without write");
   AST_TX_SF0: assert property (fall && module_enable && subframe0_enable && q.bitcnt[6:5] == 2'h0
      |=> link_dout == $past(q.sf0_ctrl[~q.bitcnt[4:0]])) else $error("wrong subframe 0 control bit");
   AST_TX_SF1: assert property (fall && module_enable && subframe1_enable && q.bitcnt[6:5] == 2'h2
      |=> link_dout == $past(q.sf1_ctrl[~q.bitcnt[4:0]])) else $error("wrong subframe 1 control bit");
   AST_ZERO_OFF: assert property (fall && !(q.bitcnt[6] ? subframe1_enable : subframe0_enable) |=> !link_dout)
      else $error("disabled subframe not zero");
   AST_STAT_KEEP: assert property ($changed(q.sf0_stat) |-> $past(subframe0_enable && module_enable))
      else $error("status 0 updated while disabled");
   AST_FRAME_WRAP: assert property (module_enable && rise && !q.fsync_sync[1]
      && q.bitcnt == `CLD_FRAME_LAST |=> q.bitcnt == 7'h00) else $error("frame not 128 bits");
   AST_DMA_RO: assert property ((q.dma_ctl & ~`CLD_DMA_WMASK) == 32'h0000_0000)
      else $error("pointer bits stored");
   AST_SND_ORDER: assert property (q.snd.phase == CLD_FIRST && q.dma_ctl[`CLD_SND_RXFIRST]
      && q.dma_ctl[`CLD_SND_RXEN] |-> sound_dma_rx_req && !sound_dma_tx_req) else $error("sound order");
   AST_TEL_ORDER: assert property (q.tel.phase == CLD_FIRST && !q.dma_ctl[`CLD_TEL_RXFIRST]
      && q.dma_ctl[`CLD_TEL_TXEN] |-> telecom_dma_tx_req && !telecom_dma_rx_req) else $error("telecom order");
   AST_SND_WRAP: assert property (q.snd.phase == CLD_SECOND && sound_dma_ack
      && q.snd.ptr == dma_buffer_size - 12'h001 && !q.dma_ctl[`CLD_SND_SINGLE]
      && (q.dma_ctl[`CLD_SND_RXEN] || q.dma_ctl[`CLD_SND_TXEN])
      |=> q.snd.ptr == 12'h000 && !q.snd.halted) else $error("sound no wrap");
   AST_TEL_HALT: assert property (q.tel.halted |-> !telecom_dma_rx_req && !telecom_dma_tx_req)
      else $error("telecom runs after end");
   AST_HOLD_FLAG: assert property (telecom_input_flag |-> $changed(q.tel_flag))
      else $error("flag longer than one cycle");

   // Register side: control writes land whole, DMA mode writes are masked, unwritten words hold
   AST_CTRL1_WRITE: assert property (q.ap_write && q.ap_addr == `CLD_OFF_SF1_CTRL
      |=> q.sf1_ctrl == $past(hwdata))
      else $error("control word 1 write lost");
   AST_CTRL0_KEEP: assert property (!(q.ap_write && q.ap_addr == `CLD_OFF_SF0_CTRL)
      |=> $stable(q.sf0_ctrl))
      else $error("control word 0 changed without write");
   AST_DMA_WRITE: assert property (q.ap_write && q.ap_addr == `CLD_OFF_DMA_CTL
      |=> q.dma_ctl == ($past(hwdata) & `CLD_DMA_WMASK))
      else $error("DMA mode write lost");
   AST_SND_PTR_RD: assert property (ap_valid && !hwrite && haddr[7:0] == `CLD_OFF_DMA_CTL
      |=> hrdata[`CLD_SND_PTR_LSB +: `CLD_PTR_W] == sound_dma_pointer)
      else $error("sound pointer field wrong");
   AST_TEL_PTR_RD: assert property (ap_valid && !hwrite && haddr[7:0] == `CLD_OFF_DMA_CTL
      |=> hrdata[`CLD_TEL_PTR_LSB +: `CLD_PTR_W] == telecom_dma_pointer)
      else $error("telecom pointer field wrong");

   // Receive side: captures only from enabled slots
   AST_STAT1_KEEP: assert property ($changed(q.sf1_stat)
      |-> $past(subframe1_enable && module_enable))
      else $error("status 1 updated while disabled");
   AST_HOLD_KEEP: assert property ($changed(q.tel_hold) |-> telecom_input_flag)
      else $error("holding changed without flag");
   AST_FLAG_SRC: assert property (telecom_input_flag
      |-> $past(telecom_enable && module_enable))
      else $error("telecom word taken while disabled");

   // DMA channels: end of buffer, skipped directions, one request at a time
   AST_SND_HALT_SET: assert property (q.snd.phase == CLD_SECOND && sound_dma_ack
      && q.snd.ptr == dma_buffer_size - 12'h001 && q.dma_ctl[`CLD_SND_SINGLE]
      && (q.dma_ctl[`CLD_SND_RXEN] || q.dma_ctl[`CLD_SND_TXEN])
      |=> q.snd.ptr == 12'h000 && q.snd.halted)
      else $error("sound runs past buffer end");
   AST_SND_HALT: assert property (q.snd.halted |-> !sound_dma_rx_req && !sound_dma_tx_req)
      else $error("sound runs after end");
   AST_TEL_WRAP: assert property (q.tel.phase == CLD_SECOND && telecom_dma_ack
      && q.tel.ptr == dma_buffer_size - 12'h001 && !q.dma_ctl[`CLD_TEL_SINGLE]
      && (q.dma_ctl[`CLD_TEL_RXEN] || q.dma_ctl[`CLD_TEL_TXEN])
      |=> q.tel.ptr == 12'h000 && !q.tel.halted)
      else $error("telecom no wrap");
   AST_TEL_HALT_SET: assert property (q.tel.phase == CLD_SECOND && telecom_dma_ack
      && q.tel.ptr == dma_buffer_size - 12'h001 && q.dma_ctl[`CLD_TEL_SINGLE]
      && (q.dma_ctl[`CLD_TEL_RXEN] || q.dma_ctl[`CLD_TEL_TXEN])
      |=> q.tel.ptr == 12'h000 && q.tel.halted)
      else $error("telecom runs past buffer end");
   AST_SND_ORDER_TX: assert property (q.snd.phase == CLD_FIRST && !q.dma_ctl[`CLD_SND_RXFIRST]
      && q.dma_ctl[`CLD_SND_TXEN] |-> sound_dma_tx_req && !sound_dma_rx_req)
      else $error("sound transmit order");
   AST_TEL_ORDER_RX: assert property (q.tel.phase == CLD_FIRST && q.dma_ctl[`CLD_TEL_RXFIRST]
      && q.dma_ctl[`CLD_TEL_RXEN] |-> telecom_dma_rx_req && !telecom_dma_tx_req)
      else $error("telecom receive order");
   AST_SND_ONE: assert property (!(sound_dma_rx_req && sound_dma_tx_req))
      else $error("sound requests overlap");
   AST_TEL_ONE: assert property (!(telecom_dma_rx_req && telecom_dma_tx_req))
      else $error("telecom requests overlap");
   AST_SND_RX_OFF: assert property (!q.dma_ctl[`CLD_SND_RXEN] |-> !sound_dma_rx_req)
      else $error("sound receive request while off");
   AST_SND_TX_OFF: assert property (!q.dma_ctl[`CLD_SND_TXEN] |-> !sound_dma_tx_req)
      else $error("sound transmit request while off");
   AST_TEL_RX_OFF: assert property (!q.dma_ctl[`CLD_TEL_RXEN] |-> !telecom_dma_rx_req)
      else $error("telecom receive request while off");
   AST_TEL_TX_OFF: assert property (!q.dma_ctl[`CLD_TEL_TXEN] |-> !telecom_dma_tx_req)
      else $error("telecom transmit request while off");

   CV_TEL_WORD: cover property (telecom_input_flag);
   CV_SND_HALT: cover property (q.snd.halted);
   CV_TEL_FULL: cover property (telecom_dma_rx_req ##[1:20] telecom_dma_tx_req);
   CV_STAT1: cover property ($changed(q.sf1_stat));
   CV_TEL_HALT: cover property (q.tel.halted);

endmodule // cld_codec_link_dma

// ==== design/cld_params.svh ====
`ifndef CLD_PARAMS_SVH
`define CLD_PARAMS_SVH

`define CLD_PTR_W 12
`define CLD_OFF_TEL_HOLD 8'h7c
`define CLD_OFF_SF0_CTRL 8'h80
`define CLD_OFF_SF1_CTRL 8'h84
`define CLD_OFF_SF0_STAT 8'h88
`define CLD_OFF_SF1_STAT 8'h8c
`define CLD_OFF_DMA_CTL 8'h90
`define CLD_DMA_WMASK 32'hc003c003
`define CLD_SND_SINGLE 31
`define CLD_SND_RXFIRST 30
`define CLD_SND_PTR_LSB 18
`define CLD_SND_RXEN 17
`define CLD_SND_TXEN 16
`define CLD_TEL_SINGLE 15
`define CLD_TEL_RXFIRST 14
`define CLD_TEL_PTR_LSB 2
`define CLD_TEL_RXEN 1
`define CLD_TEL_TXEN 0
`define CLD_FRAME_LAST 7'h7f
`define CLD_WORD_LAST 5'h1f

`endif

// ==== design/cld_pkg.sv ====
package cld_pkg;
`include "cld_params.svh"

   typedef enum logic [1:0] {CLD_IDLE, CLD_FIRST, CLD_SECOND} cld_phase_e;

   typedef struct packed {
      cld_phase_e phase;
      logic [`CLD_PTR_W-1:0] ptr;
      logic halted;
   } cld_chan_s;

   typedef struct packed {
      logic [2:0] sclk_sync;
      logic [1:0] din_sync;
      logic [1:0] fsync_sync;
      logic [6:0] bitcnt;
      logic [31:0] rx_shift;
      logic dout;
      logic [31:0] sf0_ctrl;
      logic [31:0] sf1_ctrl;
      logic [31:0] sf0_stat;
      logic [31:0] sf1_stat;
      logic [31:0] tel_hold;
      logic tel_flag;
      logic [31:0] dma_ctl;
      cld_chan_s snd;
      cld_chan_s tel;
      logic ap_write;
      logic [7:0] ap_addr;
      logic [31:0] rdata;
   } cld_state_s;
endpackage
